//--- rtl/lpc_irq_enable_defines.vh
// constants for the host interrupt enable block of data channels 2 and 3
// assumes an AXI4-Lite register port with 32-bit data and 8-bit offsets
`ifndef LPC_IRQ_ENABLE_DEFINES_VH
`define LPC_IRQ_ENABLE_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_ENABLE 8'h00
`define OFS_CONTROL 8'h04
`define OFS_POLARITY 8'h08
`define OFS_STATE 8'h0C
`define OFS_EVENT 8'h10
`define OFS_EVENT_MASK 8'h14

// ****************************************
// enable register bit positions
// ****************************************
`define BIT_IRQ6_CH2 0
`define BIT_IRQ9_CH2 1
`define BIT_IRQ10_CH2 2
`define BIT_IRQ11_CH2 3
`define BIT_IRQ6_CH3 4
`define BIT_IRQ9_CH3 5

// ****************************************
// control, polarity, state and event fields
// ****************************************
`define BIT_DIRECT_CH2 0
`define BIT_DIRECT_CH3 1
`define BIT_POL_IRQ6 0
`define BIT_POL_IRQ9 1
`define BIT_POL_IRQ10 2
`define BIT_POL_IRQ11 3
`define BIT_STATE_OUT_BUFFER_FULL_CH2 0
`define BIT_STATE_OBF3 1
`define LSB_STATE_REQ 4
`define BIT_EV_OUT_BUFFER_FULL_CH2_SET 0
`define BIT_EV_OBF3_SET 1
`define BIT_EV_AUTO_CLR2 2
`define BIT_EV_AUTO_CLR3 3

// ****************************************
// reset values and bus answers
// ****************************************
`define RST_ENABLE 6'h00
`define RST_CONTROL 2'h0
`define RST_POLARITY 4'h0
`define RST_EVENT 4'h0
`define RST_EVENT_MASK 4'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/lpc_host_irq_enable.v
// host interrupt enables of LPC data channels 2 and 3, with AXI4-Lite registers
// assumes output buffer full flags and reset pulses synchronous to CLOCK
//
// Behaviour
// - ch3 irq9 enable requests irq9 on buffer full
// - ch3 irq6 enable requests irq6 on buffer full
// - ch2 irq11 enable requests irq11 on buffer full
// - ch2 irq10 enable requests irq10 on buffer full
// - ch2 irq9 enable requests irq9 on buffer full
// - ch2 irq6 enable requests irq6 on buffer full
// - ch3 direct mode: enable alone requests
// - ch2 direct mode: enable alone requests
// - enable at zero blocks its request
// - enables cleared by write zero, lpc resets
// - ch3 buffer emptying clears ch3 enables, with ch3 direct mode off
// - ch2 buffer emptying clears ch2 enables, with ch2 direct mode off
// - enable sets only after reading zero
// - request needs enable and full, unless direct
// - polarity select inverts serial irq drive
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "lpc_irq_enable_defines.vh"

module lpc_host_irq_enable #(
  parameter ADDR_WIDTH = 8
) (
  input wire CLOCK,
  input wire RESETN,
  // axi4-lite slave
  input wire [ADDR_WIDTH-1:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [ADDR_WIDTH-1:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // channel flags and lpc resets
  input wire OUT_BUFFER_FULL_CH2,
  input wire OUT_BUFFER_FULL_CH3,
  input wire LPC_HW_RESET,
  input wire LPC_SW_RESET,
  // host interrupt requests
  output reg HOST_INTERRUPT_6,
  output reg HOST_INTERRUPT_9,
  output reg HOST_INTERRUPT_10,
  output reg HOST_INTERRUPT_11,
  // serial irq drive per request: 6, 9, 10, 11
  output reg [3:0] SERIAL_IRQ_O,
  output reg [3:0] SERIAL_IRQ_OE,
  output reg INTERRUPT
);

  // ****************************************
  // state
  // ****************************************
  reg [5:0] enable;
  reg [5:0] armed;
  reg [1:0] direct;
  reg [3:0] polarity;
  reg [3:0] event_status;
  reg [3:0] event_mask;
  reg out_buffer_full_ch2_q;
  reg obf3_q;
  reg aw_full;
  reg w_full;
  reg [ADDR_WIDTH-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // ****************************************
  // functions
  // ****************************************
  // true when the offset is one of the mapped words
  function mapped;
    input [ADDR_WIDTH-1:0] a;
    begin
      mapped = (a[7:0] == `OFS_ENABLE) || (a[7:0] == `OFS_CONTROL) ||
        (a[7:0] == `OFS_POLARITY) || (a[7:0] == `OFS_STATE) ||
        (a[7:0] == `OFS_EVENT) || (a[7:0] == `OFS_EVENT_MASK);
    end
  endfunction

  // gate of one enable: direct mode or buffer full
  function gate;
    input en;
    input dir;
    input obf;
    begin
      gate = en & (dir | obf);
    end
  endfunction

  // ****************************************
  // bus handshakes
  // ****************************************
  // a slot holds each write item until its partner arrives; no new item
  // is taken while a write answer waits for bready
  wire aw_take = S_AXI_AWVALID & ~aw_full & ~S_AXI_BVALID;
  wire w_take = S_AXI_WVALID & ~w_full & ~S_AXI_BVALID;
  wire ar_take = S_AXI_ARVALID & ~S_AXI_RVALID;
  wire do_write = aw_full & w_full & ~S_AXI_BVALID;
  wire wr_low = do_write & w_strb[0];
  wire [7:0] wb = w_data[7:0];

  assign S_AXI_AWREADY = ~aw_full & ~S_AXI_BVALID;
  assign S_AXI_WREADY = ~w_full & ~S_AXI_BVALID;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  // write address and data are held until both are present
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= {ADDR_WIDTH{1'b0}};
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_full <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // ****************************************
  // write decode
  // ****************************************
  // one strobe per writable word; only the low byte carries fields, so a
  // write without its lowest strobe leaves every register alone
  wire wr_enable = wr_low & (aw_addr[7:0] == `OFS_ENABLE);
  wire wr_control = wr_low & (aw_addr[7:0] == `OFS_CONTROL);
  wire wr_polarity = wr_low & (aw_addr[7:0] == `OFS_POLARITY);
  wire wr_mask = wr_low & (aw_addr[7:0] == `OFS_EVENT_MASK);
  wire ev_write = wr_low & (aw_addr[7:0] == `OFS_EVENT);

  // ****************************************
  // buffer flag edges
  // ****************************************
  // the registered copies start low, the idle level of both flags, so no
  // false edge follows reset; auto clear only acts with direct mode off
  wire out_buffer_full_ch2_fall = out_buffer_full_ch2_q & ~OUT_BUFFER_FULL_CH2;
  wire obf3_fall = obf3_q & ~OUT_BUFFER_FULL_CH3;
  wire out_buffer_full_ch2_rise = ~out_buffer_full_ch2_q & OUT_BUFFER_FULL_CH2;
  wire obf3_rise = ~obf3_q & OUT_BUFFER_FULL_CH3;
  wire auto_clr2 = out_buffer_full_ch2_fall & ~direct[`BIT_DIRECT_CH2];
  wire auto_clr3 = obf3_fall & ~direct[`BIT_DIRECT_CH3];
  wire lpc_reset = LPC_HW_RESET | LPC_SW_RESET;

  // one-cycle history of each buffer full flag
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      out_buffer_full_ch2_q <= 1'b0;
      obf3_q <= 1'b0;
    end else begin
      out_buffer_full_ch2_q <= OUT_BUFFER_FULL_CH2;
      obf3_q <= OUT_BUFFER_FULL_CH3;
    end
  end

  // ****************************************
  // enable bits
  // ****************************************
  wire en_read = ar_take & (S_AXI_ARADDR[7:0] == `OFS_ENABLE);
  reg [5:0] next_enable;
  reg [5:0] next_armed;

  // a read of the word arms every bit that reads zero; the next write of
  // the word may set only armed bits and disarms all of them, so a stale
  // read cannot set a bit later. clears are applied last: an lpc reset
  // beats a buffer-emptying clear, which beats a software write
  always @* begin
    next_enable = enable;
    next_armed = armed;
    if (en_read) begin
      next_armed = armed | ~enable;
    end
    if (wr_enable) begin
      next_enable = (enable | (wb[5:0] & armed)) & wb[5:0];
      next_armed = 6'h00;
    end
    if (auto_clr2) begin
      next_enable[3:0] = 4'h0;
    end
    if (auto_clr3) begin
      next_enable[5:4] = 2'h0;
    end
    if (lpc_reset) begin
      next_enable = `RST_ENABLE;
      next_armed = 6'h00;
    end
  end

  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      enable <= `RST_ENABLE;
      armed <= 6'h00;
    end else begin
      enable <= next_enable;
      armed <= next_armed;
    end
  end

  // ****************************************
  // control, polarity, events and mask
  // ****************************************
  wire [3:0] ev_set = {auto_clr3, auto_clr2, obf3_rise, out_buffer_full_ch2_rise};

  // status after this cycle's update: a new event wins over a write-one
  // clear in the same cycle, so an event is never lost to a late clear
  reg [3:0] next_event_status;
  always @* begin
    next_event_status = event_status;
    if (ev_write) begin
      next_event_status = event_status & ~wb[3:0];
    end
    next_event_status = next_event_status | ev_set;
  end

  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      direct <= `RST_CONTROL;
      polarity <= `RST_POLARITY;
      event_status <= `RST_EVENT;
      event_mask <= `RST_EVENT_MASK;
    end else begin
      if (wr_control) begin
        direct <= wb[1:0];
      end
      if (wr_polarity) begin
        polarity <= wb[3:0];
      end
      if (wr_mask) begin
        event_mask <= wb[3:0];
      end
      event_status <= next_event_status;
    end
  end

  // ****************************************
  // host requests
  // ****************************************
  wire out_buffer_full_ch2 = OUT_BUFFER_FULL_CH2;
  wire obf3 = OUT_BUFFER_FULL_CH3;
  wire dir2 = direct[`BIT_DIRECT_CH2];
  wire dir3 = direct[`BIT_DIRECT_CH3];
  // channel 3 has no irq10 or irq11 enable here, so those two requests
  // come from channel 2 alone; requests follow the flag level, not its edge
  wire req6 = gate(enable[`BIT_IRQ6_CH2], dir2, out_buffer_full_ch2) |
    gate(enable[`BIT_IRQ6_CH3], dir3, obf3);
  wire req9 = gate(enable[`BIT_IRQ9_CH2], dir2, out_buffer_full_ch2) |
    gate(enable[`BIT_IRQ9_CH3], dir3, obf3);
  wire req10 = gate(enable[`BIT_IRQ10_CH2], dir2, out_buffer_full_ch2);
  wire req11 = gate(enable[`BIT_IRQ11_CH2], dir2, out_buffer_full_ch2);
  wire [3:0] req = {req11, req10, req9, req6};

  // requests, serial drive and interrupt registered
  // the serial pins only ever pull low: the polarity bit picks whether a
  // pull means request set or request cleared
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      HOST_INTERRUPT_6 <= 1'b0;
      HOST_INTERRUPT_9 <= 1'b0;
      HOST_INTERRUPT_10 <= 1'b0;
      HOST_INTERRUPT_11 <= 1'b0;
      SERIAL_IRQ_O <= 4'h0;
      SERIAL_IRQ_OE <= 4'h0;
      INTERRUPT <= 1'b0;
    end else begin
      HOST_INTERRUPT_6 <= req6;
      HOST_INTERRUPT_9 <= req9;
      HOST_INTERRUPT_10 <= req10;
      HOST_INTERRUPT_11 <= req11;
      SERIAL_IRQ_O <= 4'h0; // drive is always low
      SERIAL_IRQ_OE <= req ^ polarity;
      INTERRUPT <= |(next_event_status & event_mask);
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  reg [31:0] rd_word;

  // read data mux; unmapped offsets read zero
  always @* begin
    rd_word = 32'h0000_0000;
    case (S_AXI_ARADDR[7:0])
      `OFS_ENABLE: rd_word[5:0] = enable;
      `OFS_CONTROL: rd_word[1:0] = direct;
      `OFS_POLARITY: rd_word[3:0] = polarity;
      `OFS_STATE: begin
        rd_word[`BIT_STATE_OUT_BUFFER_FULL_CH2] = out_buffer_full_ch2;
        rd_word[`BIT_STATE_OBF3] = obf3;
        rd_word[`LSB_STATE_REQ+3:`LSB_STATE_REQ] = {HOST_INTERRUPT_11,
          HOST_INTERRUPT_10, HOST_INTERRUPT_9, HOST_INTERRUPT_6};
      end
      `OFS_EVENT: rd_word[3:0] = event_status;
      `OFS_EVENT_MASK: rd_word[3:0] = event_mask;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // read answer one cycle after the address is taken
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `RESP_OKAY;
    end else begin
      if (ar_take) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_word;
        S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule

//--- dv/lpc_host_irq_enable_properties.sv
// port checks for the host interrupt enable block
// assumes one clock domain and a bind by name into the block
`timescale 1ns/1ps
`include "lpc_irq_enable_defines.vh"

module irq_enable_checker #(
  parameter ADDR_WIDTH = 8
) (
  input wire CLOCK,
  input wire RESETN,
  input wire [ADDR_WIDTH-1:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0] S_AXI_RRESP,
  input wire S_AXI_RVALID,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire OUT_BUFFER_FULL_CH2,
  input wire LPC_HW_RESET,
  input wire LPC_SW_RESET,
  input wire HOST_INTERRUPT_6,
  input wire HOST_INTERRUPT_9,
  input wire HOST_INTERRUPT_10,
  input wire HOST_INTERRUPT_11,
  input wire [3:0] SERIAL_IRQ_O
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  wire any_req = HOST_INTERRUPT_6 | HOST_INTERRUPT_9 | HOST_INTERRUPT_10 | HOST_INTERRUPT_11;
  // a reset pulse leaves no request once the enables are gone
  a_hw_reset_clear: assert property (LPC_HW_RESET |-> ##2 !any_req)
    else $error("request after lpc hardware reset");
  a_sw_reset_clear: assert property (LPC_SW_RESET |-> ##2 !any_req)
    else $error("request after lpc software reset");
  a_drive_low: assert property (SERIAL_IRQ_O == 4'h0)
    else $error("serial irq drives high");
  a_irq10_cause: assert property ($rose(HOST_INTERRUPT_10) |->
    $past(OUT_BUFFER_FULL_CH2) || $past(S_AXI_BVALID))
    else $error("irq10 rose without buffer full or write");
  a_bvalid_drop: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answer held after handshake");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_unmapped_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
    S_AXI_ARADDR > `OFS_EVENT_MASK |=> S_AXI_RRESP == `RESP_SLVERR && S_AXI_RDATA == 0)
    else $error("unmapped read not refused");
  a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
  c_direct_req: cover property (HOST_INTERRUPT_11 && !OUT_BUFFER_FULL_CH2);
  c_hw_reset: cover property (LPC_HW_RESET && any_req);
  c_req_fall: cover property ($fell(HOST_INTERRUPT_6));
endmodule

bind lpc_host_irq_enable irq_enable_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk_i (.*);

//--- dv/serirq_host_model.sv
// host end of the serial irq lines, one open-drain line per request
// assumes a pull-up on each line and no other driver
`timescale 1ns/1ps

module serirq_host_model (
  input wire [3:0] drive,
  input wire [3:0] drive_en,
  output wire [3:0] line
);
  // a released line floats up to the pull-up level
  assign line = (drive_en & drive) | ~drive_en;
endmodule

//--- dv/testbench.sv
// self-checking bench for the host interrupt enable block
// assumes the block, its defines, the checker and the host model
`timescale 1ns/1ps
`include "lpc_irq_enable_defines.vh"

module testbench;
  // ****************************************
  // stimulus and checks
  // ****************************************
  localparam logic [31:0] NONE = 32'h0000_0000;
  logic CLOCK = 1'b0, RESETN = 1'b0;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = NONE, rdata;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, LPC_HW_RESET = 1'b0, LPC_SW_RESET = 1'b0;
  logic OUT_BUFFER_FULL_CH2 = 1'b0, OUT_BUFFER_FULL_CH3 = 1'b0;
  logic [1:0] resp;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, INTERRUPT;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  wire HOST_INTERRUPT_6, HOST_INTERRUPT_9, HOST_INTERRUPT_10, HOST_INTERRUPT_11;
  wire [3:0] SERIAL_IRQ_O, SERIAL_IRQ_OE, line;
  wire [3:0] req = {HOST_INTERRUPT_11, HOST_INTERRUPT_10, HOST_INTERRUPT_9, HOST_INTERRUPT_6};
  int error_cnt = 0, checked = 0;
  lpc_host_irq_enable lpc_host_irq_enable_i (.S_AXI_WSTRB(4'hF), .*);
  serirq_host_model serirq_host_model_i (
    .drive(SERIAL_IRQ_O),
    .drive_en(SERIAL_IRQ_OE),
    .line(line)
  );
  // free-running clock and a watchdog on the whole run
  initial begin
    forever #4 CLOCK = ~CLOCK;
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    error_cnt++;
    finish_test;
  end
  task finish_test;
    begin
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checked++;
      if (seen !== exp) begin
        error_cnt++;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  // address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge CLOCK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'b111;
      do begin
        @(posedge CLOCK);
        if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
        if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (!S_AXI_BVALID);
      resp = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
    end
  endtask
  task rd(input logic [7:0] a);
    begin
      @(posedge CLOCK);
      S_AXI_ARADDR <= a;
      {S_AXI_ARVALID, S_AXI_RREADY} <= 2'b11;
      do begin
        @(posedge CLOCK);
        if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (!S_AXI_RVALID);
      rdata = S_AXI_RDATA;
      resp = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
    end
  endtask
  // reset values, set without a prior read, unmapped read
  task t_regs;
    begin
      rd(`OFS_POLARITY);
      chk(rdata, NONE);
      wr(`OFS_ENABLE, 32'h0000_003F);
      rd(`OFS_ENABLE);
      chk(rdata, NONE);
      wr(`OFS_ENABLE, 32'h0000_003F);
      rd(`OFS_ENABLE);
      chk(rdata, 32'h0000_003F);
      wr(`OFS_ENABLE, NONE);
      chk(resp, `RESP_OKAY);
      wr(8'h40, 32'h0000_003F);
      chk(resp, `RESP_SLVERR);
      rd(8'h40);
      chk(resp, `RESP_SLVERR);
      chk(rdata, NONE);
    end
  endtask
  // each enable alone against its buffer flag, then auto clear
  task t_bits;
    int i;
    logic [3:0] exp;
    begin
      for (i = 0; i < 6; i++) begin
        exp = (i < 4) ? 4'h1 << i : 4'h1 << (i - 4);
        @(posedge CLOCK);
        {OUT_BUFFER_FULL_CH3, OUT_BUFFER_FULL_CH2} <= (i < 4) ? 2'b01 : 2'b10;
        idle(3);
        chk(req, 4'h0);
        rd(`OFS_ENABLE);
        wr(`OFS_ENABLE, 32'h0000_0001 << i);
        idle(2);
        chk(req, exp);
        chk(line, {28'h000_0000, ~exp});
        {OUT_BUFFER_FULL_CH3, OUT_BUFFER_FULL_CH2} <= 2'b00;
        idle(3);
        chk(req, 4'h0);
        rd(`OFS_ENABLE);
        chk(rdata, NONE);
      end
    end
  endtask
  // direct mode, inverted drive, clears by write and lpc resets
  task t_direct;
    int i;
    begin
      wr(`OFS_CONTROL, 32'h0000_0003);
      rd(`OFS_ENABLE);
      wr(`OFS_ENABLE, 32'h0000_003F);
      idle(2);
      chk(req, 4'hF);
      rd(`OFS_STATE);
      chk(rdata, 32'h0000_00F0);
      wr(`OFS_POLARITY, 32'h0000_000F);
      idle(2);
      chk(line, 4'hF);
      wr(`OFS_ENABLE, NONE);
      idle(2);
      chk(req, 4'h0);
      chk(line, 4'h0);
      for (i = 0; i < 2; i++) begin
        rd(`OFS_ENABLE);
        wr(`OFS_ENABLE, 32'h0000_003F);
        {LPC_SW_RESET, LPC_HW_RESET} <= i ? 2'b10 : 2'b01;
        @(posedge CLOCK);
        {LPC_SW_RESET, LPC_HW_RESET} <= 2'b00;
        rd(`OFS_ENABLE);
        chk(rdata, NONE);
      end
      wr(`OFS_CONTROL, NONE);
      wr(`OFS_POLARITY, NONE);
    end
  endtask
  // event raised while masked, unmasked, then cleared by a one
  task t_irq;
    begin
      rd(`OFS_EVENT);
      chk(rdata, 32'h0000_000F);
      wr(`OFS_EVENT, 32'h0000_000F);
      OUT_BUFFER_FULL_CH2 <= 1'b1;
      idle(3);
      chk(INTERRUPT, 1'b0);
      rd(`OFS_EVENT);
      chk(rdata[0], 1'b1);
      wr(`OFS_EVENT_MASK, 32'h0000_0001);
      idle(2);
      chk(INTERRUPT, 1'b1);
      wr(`OFS_EVENT, 32'h0000_0001);
      idle(2);
      chk(INTERRUPT, 1'b0);
    end
  endtask
  initial begin
    repeat (20) @(posedge CLOCK);
    RESETN <= 1'b1;
    t_regs;
    t_bits;
    t_direct;
    t_irq;
    finish_test;
  end
endmodule
